//--- core/swg_pkg.sv
package swg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FREQ_W = 16;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_AMP = 8'h04;
  localparam logic [7:0] OFF_JUMP = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0C;
  localparam logic [7:0] OFF_RISE = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam int CTRL_SEL_BIT = 0;
  localparam int ST_FALL_BIT = 16;
  localparam int ST_ACT_BIT = 17;
  localparam logic [9:0] PCT_FULL = 10'h3E8;
  localparam logic [9:0] AMP_MAX = 10'h3E8;
  localparam logic [9:0] JUMP_MAX = 10'h1F4;
  localparam logic [14:0] PERIOD_MAX = 15'h7530;
  localparam logic [0:0] SEL_RST = 1'h0;
  localparam logic [9:0] AMP_RST = 10'h000;
  localparam logic [9:0] JUMP_RST = 10'h000;
  localparam logic [14:0] PERIOD_RST = 15'h0064;
  localparam logic [9:0] RISE_RST = 10'h1F4;
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_TIME_NS = 100000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int DIV_NUM_W = 48;
  localparam int DIV_DEN_W = 32;
  localparam int DIV_CNT_W = 6;
endpackage

//--- core/swg_div.sv
`timescale 1ns/10ps
module swg_div
  import swg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [DIV_NUM_W-1:0] dividend,
  input wire logic [DIV_DEN_W-1:0] divisor,
  output logic busy,
  output logic done,
  output logic [DIV_NUM_W-1:0] quotient
);
  logic [DIV_DEN_W-1:0] rem_reg;
  logic [DIV_DEN_W-1:0] den_reg;
  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_DEN_W:0] trial;
  logic ge;

  // One quotient bit per cycle keeps the area small; a result needs
  // DIV_NUM_W cycles, far below the update tick.
  always_comb begin
    trial = {rem_reg, quotient[DIV_NUM_W-1]};
    ge = trial >= {1'b0, den_reg};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_reg <= '0;
      den_reg <= '0;
      cnt_reg <= '0;
      quotient <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        quotient <= dividend;
        rem_reg <= '0;
        den_reg <= divisor;
        cnt_reg <= DIV_CNT_W'(DIV_NUM_W);
        busy <= 1'b1;
      end else if (busy) begin
        rem_reg <= ge ? DIV_DEN_W'(trial - {1'b0, den_reg})
                      : trial[DIV_DEN_W-1:0];
        quotient <= {quotient[DIV_NUM_W-2:0], ge};
        cnt_reg <= cnt_reg - 1'b1;
        if (cnt_reg == DIV_CNT_W'(1'h1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule

//--- core/swg_core.sv
// Behaviour
// - Select 0: amplitude is set frequency times the amplitude per-mille.
// - Select 1: amplitude is maximum frequency times amplitude per-mille.
// - Jump frequency is the amplitude times the jump per-mille, 0 to 500.
// - The swing output is clamped to the lower and upper limit.
// - One swing takes the period, 0.0 s to 3000.0 s, default 10.0 s.
// - The rise lasts the period times the rise coefficient, default 50.0%.
// - The fall lasts the period times one minus the rise coefficient.
// - The output swings up and down about the set frequency as its center.
// - A zero amplitude setting disables swing and passes the set frequency.
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module swg_core
  import swg_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
)
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic RUN,
  input wire logic [FREQ_W-1:0] SET_FREQ,
  input wire logic [FREQ_W-1:0] MAX_FREQ,
  input wire logic [FREQ_W-1:0] UPPER_FREQ,
  input wire logic [FREQ_W-1:0] LOWER_FREQ,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  output logic [FREQ_W-1:0] FREQ_OUT,
  output logic SWING_ACTIVE
);
  logic sel_reg;
  logic [9:0] amp_reg;
  logic [9:0] jump_reg;
  logic [14:0] period_reg;
  logic [9:0] rise_reg;
  logic [31:0] tick_cnt_reg;
  logic tick_reg;
  logic [31:0] pos_reg;
  logic fall_reg;
  logic [18:0] start_reg;
  logic dir_reg;
  logic [15:0] base;
  logic [25:0] amp_prod;
  logic [15:0] swing_amplitude_value;
  logic [25:0] jump_prod;
  logic [15:0] jmp;
  logic [31:0] rise_ticks;
  logic [31:0] fall_ticks;
  logic [31:0] cur_ticks;
  logic [16:0] span;
  logic bypass;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [DIV_NUM_W-1:0] div_q;
  logic [18:0] ramp;
  logic [15:0] clamped;
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    base = sel_reg ? MAX_FREQ : SET_FREQ;
    amp_prod = 26'(base) * 26'(amp_reg);
    swing_amplitude_value = 16'(amp_prod / 26'(PCT_FULL));
    jump_prod = 26'(swing_amplitude_value) * 26'(jump_reg);
    jmp = 16'(jump_prod / 26'(PCT_FULL));
    rise_ticks = 32'(period_reg) * 32'(rise_reg);
    fall_ticks = 32'(period_reg) * 32'(PCT_FULL - rise_reg);
    cur_ticks = fall_reg ? fall_ticks : rise_ticks;
    span = 17'({swing_amplitude_value, 1'b0}) - 17'(jmp);
    bypass = !RUN || (amp_reg == '0) || (period_reg == '0);
    div_start = tick_reg && !bypass && (cur_ticks != '0);
  end

  // Register writes; out-of-range amplitude, jump, period and rise values saturate at the top of range; control keeps bit 0 only.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sel_reg <= SEL_RST;
      amp_reg <= AMP_RST;
      jump_reg <= JUMP_RST;
      period_reg <= PERIOD_RST;
      rise_reg <= RISE_RST;
    end else if (WR) begin
      case (ADDR)
        OFF_CTRL: sel_reg <= WDATA[CTRL_SEL_BIT];
        OFF_AMP: amp_reg <= (WDATA > 32'(AMP_MAX)) ? AMP_MAX : WDATA[9:0];
        OFF_JUMP: jump_reg <= (WDATA > 32'(JUMP_MAX)) ? JUMP_MAX : WDATA[9:0];
        OFF_PERIOD: period_reg <= (WDATA > 32'(PERIOD_MAX)) ? PERIOD_MAX
                                                             : WDATA[14:0];
        OFF_RISE: rise_reg <= (WDATA > 32'(PCT_FULL)) ? PCT_FULL : WDATA[9:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ADDR)
      OFF_CTRL: rd_mux = {31'h0, sel_reg};
      OFF_AMP: rd_mux = {22'h0, amp_reg};
      OFF_JUMP: rd_mux = {22'h0, jump_reg};
      OFF_PERIOD: rd_mux = {17'h0, period_reg};
      OFF_RISE: rd_mux = {22'h0, rise_reg};
      OFF_STATUS: begin
        rd_mux = {16'h0, FREQ_OUT};
        rd_mux[ST_FALL_BIT] = fall_reg;
        rd_mux[ST_ACT_BIT] = SWING_ACTIVE;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else begin
      RDATA <= RD ? rd_mux : '0;
    end
  end

  // A 100 us tick: the period is in tenths of a second, so a period unit
  // is exactly 1000 ticks and the rise time needs no division.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == 32'(TICK_CYC - 1));
      tick_cnt_reg <= (tick_cnt_reg == 32'(TICK_CYC - 1)) ? '0
                                                        : tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pos_reg <= '0;
      fall_reg <= 1'b0;
    end else if (bypass) begin
      pos_reg <= '0;
      fall_reg <= 1'b0;
    end else if (tick_reg) begin
      if (pos_reg + 1'b1 >= cur_ticks) begin
        pos_reg <= '0;
        fall_reg <= !fall_reg;
      end else begin
        pos_reg <= pos_reg + 1'b1;
      end
    end
  end

  // The ramp starts a jump away from the peak it left, then runs to the
  // opposite peak, both peaks sitting one amplitude from the center.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      start_reg <= '0;
      dir_reg <= 1'b0;
    end else if (div_start) begin
      dir_reg <= fall_reg;
      if (fall_reg) begin
        start_reg <= 19'(SET_FREQ) + 19'(swing_amplitude_value)
                     - 19'(jmp);
      end else begin
        start_reg <= 19'(SET_FREQ) - 19'(swing_amplitude_value)
                     + 19'(jmp);
      end
    end
  end

  swg_div swg_div_i (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start(div_start),
    .dividend(48'(span) * 48'(pos_reg)),
    .divisor(cur_ticks),
    .busy(div_busy),
    .done(div_done),
    .quotient(div_q)
  );

  always_comb begin
    ramp = dir_reg ? start_reg - 19'(div_q) : start_reg + 19'(div_q);
    if ($signed(ramp) > $signed({3'h0, UPPER_FREQ})) begin
      clamped = UPPER_FREQ;
    end else if ($signed(ramp) < $signed({3'h0, LOWER_FREQ})) begin
      clamped = LOWER_FREQ;
    end else begin
      clamped = ramp[15:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      FREQ_OUT <= '0;
      SWING_ACTIVE <= 1'b0;
    end else begin
      SWING_ACTIVE <= !bypass;
      if (bypass) begin
        FREQ_OUT <= SET_FREQ;
      end else if (div_done) begin
        FREQ_OUT <= clamped;
      end
    end
  end

  a_bypass_pass: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (amp_reg == '0) |=> (FREQ_OUT == $past(SET_FREQ)))
    else $error("zero amplitude did not pass set frequency");

  a_upper_clamp: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (div_done && !bypass && LOWER_FREQ <= UPPER_FREQ)
      |=> (FREQ_OUT <= $past(UPPER_FREQ)))
    else $error("swing output above upper limit");

  a_lower_clamp: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (div_done && !bypass && LOWER_FREQ <= UPPER_FREQ)
      |=> (FREQ_OUT >= $past(LOWER_FREQ)))
    else $error("swing output below lower limit");

  a_amp_center: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !sel_reg |-> (32'(swing_amplitude_value) * 32'(PCT_FULL)
      <= 32'(SET_FREQ) * 32'(amp_reg)
      && 32'(SET_FREQ) * 32'(amp_reg)
      < (32'(swing_amplitude_value) + 32'h1) * 32'(PCT_FULL)))
    else $error("center-relative amplitude wrong");

  a_amp_maximum: assert property (@(posedge CLOCK) disable iff (!RST_N)
    sel_reg |-> (32'(swing_amplitude_value) * 32'(PCT_FULL)
      <= 32'(MAX_FREQ) * 32'(amp_reg)
      && 32'(MAX_FREQ) * 32'(amp_reg)
      < (32'(swing_amplitude_value) + 32'h1) * 32'(PCT_FULL)))
    else $error("maximum-relative amplitude wrong");

  a_jump_bound: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (17'(jmp) * 17'h2 <= 17'(swing_amplitude_value))
      && (jump_reg != '0 || jmp == '0))
    else $error("jump frequency out of range");

  a_period_split: assert property (@(posedge CLOCK) disable iff (!RST_N)
    rise_ticks + fall_ticks == 32'(period_reg) * 32'h3E8)
    else $error("rise and fall do not fill the period");

  a_rise_end: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (tick_reg && !bypass && !fall_reg && rise_ticks != '0
      && pos_reg == rise_ticks - 1) |=> (fall_reg && pos_reg == '0))
    else $error("rise did not end on time");

  a_fall_end: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (tick_reg && !bypass && fall_reg && fall_ticks != '0
      && pos_reg < fall_ticks - 32'h1)
      |=> (fall_reg && pos_reg == $past(pos_reg) + 32'h1))
    else $error("fall ended early");

  a_cycle_restart: assert property (@(posedge CLOCK)
    disable iff (!RST_N)
    (tick_reg && !bypass && fall_reg && pos_reg + 1 >= fall_ticks)
      ##1 !bypass |-> !fall_reg && pos_reg == '0)
    else $error("triangle did not restart");
endmodule

//--- tb/swg_drive_model.sv
`timescale 1ns/10ps
// Stands in for the drive's command path. Settings change only just after
// an edge, so the core never samples a half-updated set of limits.
module swg_drive_model
  import swg_pkg::*;
(
  input wire logic clk,
  output logic run,
  output logic [FREQ_W-1:0] set_freq,
  output logic [FREQ_W-1:0] max_freq,
  output logic [FREQ_W-1:0] upper_freq,
  output logic [FREQ_W-1:0] lower_freq
);
  initial begin
    run = 1'h0;
    set_freq = 16'h03E8;
    max_freq = 16'h07D0;
    upper_freq = 16'hFFFF;
    lower_freq = 16'h0000;
  end
  task automatic drive(input logic r, input logic [15:0] s, m, u, l);
    @(posedge clk);
    run <= r;
    set_freq <= s;
    max_freq <= m;
    upper_freq <= u;
    lower_freq <= l;
  endtask
endmodule

//--- tb/swg_core_bench.sv
`timescale 1ns/10ps
module swg_core_bench;
  import swg_pkg::*;
  // Small tick keeps a whole swing period near 64000 cycles.
  localparam int TK = 64;
  logic clk, rst_n, run, wr_stb, rd_stb, act;
  logic [FREQ_W-1:0] setf, maxf, upf, lof, fout;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, d;
  int failures, check_count, n, r;
  swg_core #(.TICK_CYC(TK)) swg_core_i (.CLOCK(clk), .RST_N(rst_n),
    .RUN(run), .SET_FREQ(setf), .MAX_FREQ(maxf), .UPPER_FREQ(upf),
    .LOWER_FREQ(lof), .ADDR(addr), .WDATA(wdata), .WR(wr_stb),
    .RD(rd_stb), .RDATA(rdata), .FREQ_OUT(fout), .SWING_ACTIVE(act));
  swg_drive_model swg_drive_model_i (.clk(clk), .run(run),
    .set_freq(setf), .max_freq(maxf), .upper_freq(upf),
    .lower_freq(lof));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'h1;
    @(posedge clk);
    wr_stb <= 1'h0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk);
    rd_stb <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic cfg(input logic [31:0] s, am, j, p, ri);
    bus_wr(OFF_CTRL, s);
    bus_wr(OFF_AMP, am);
    bus_wr(OFF_JUMP, j);
    bus_wr(OFF_PERIOD, p);
    bus_wr(OFF_RISE, ri);
  endtask
  // Counts edges until the output match state equals eq; a hang is a miss.
  task automatic wait_eq(input logic [15:0] v, input logic eq,
                         input int lim, output int c);
    c = 0;
    while (((fout === v) != eq) && c < lim) begin
      @(posedge clk);
      #1 c++;
    end
    if (c >= lim) begin
      failures++;
      $display("wrong value wait expected %0h seen %0h", v, fout);
    end
  endtask
  task automatic t_defaults;
    logic [7:0] offs [5];
    logic [31:0] defs [5];
    offs = '{OFF_CTRL, OFF_AMP, OFF_JUMP, OFF_PERIOD, OFF_RISE};
    defs = '{32'h0, 32'h0, 32'h0, 32'h64, 32'h1F4};
    foreach (offs[i]) begin
      bus_rd(offs[i], d);
      chk("default", defs[i], d);
    end
    bus_rd(8'h18, d);
    chk("unmapped", 32'h0, d);
    bus_wr(OFF_AMP, 32'h7D0);
    bus_rd(OFF_AMP, d);
    chk("amp saturate", 32'h3E8, d);
    bus_wr(OFF_JUMP, 32'h3E8);
    bus_rd(OFF_JUMP, d);
    chk("jump saturate", 32'h1F4, d);
    bus_wr(OFF_PERIOD, 32'hFFFF);
    bus_rd(OFF_PERIOD, d);
    chk("period saturate", 32'h7530, d);
    bus_wr(OFF_AMP, 32'h0);
    swg_drive_model_i.drive(1'h1, 16'h04D2, 16'h07D0, 16'hFFFF, 16'h0);
    repeat (3) @(posedge clk);
    #1 chk("bypass out", 32'h4D2, {16'h0, fout});
    chk("bypass active", 32'h0, {31'h0, act});
    bus_rd(OFF_STATUS, d);
    chk("status", 32'h4D2, d);
    swg_drive_model_i.drive(1'h0, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h0);
    $display("test defaults done");
  endtask
  task automatic t_center_max;
    cfg(32'h0, 32'h64, 32'h1F4, 32'h1, 32'h3E8);
    swg_drive_model_i.drive(1'h1, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h0);
    wait_eq(16'h03E8, 1'h0, 300, n);
    chk("center start", 32'h3B6, {16'h0, fout});
    chk("active", 32'h1, {31'h0, act});
    swg_drive_model_i.drive(1'h0, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h0);
    repeat (3) @(posedge clk);
    swg_drive_model_i.drive(1'h1, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h03C0);
    wait_eq(16'h03E8, 1'h0, 300, n);
    chk("lower clamp", 32'h3C0, {16'h0, fout});
    swg_drive_model_i.drive(1'h0, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h0);
    bus_wr(OFF_CTRL, 32'h1);
    swg_drive_model_i.drive(1'h1, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h0);
    wait_eq(16'h03E8, 1'h0, 300, n);
    chk("max start", 32'h384, {16'h0, fout});
    swg_drive_model_i.drive(1'h0, 16'h03E8, 16'h07D0, 16'hFFFF, 16'h0);
    $display("test center and max done");
  endtask
  task automatic t_period;
    cfg(32'h0, 32'h64, 32'h0, 32'h1, 32'h1);
    swg_drive_model_i.drive(1'h1, 16'h03E8, 16'h07D0, 16'h0438, 16'h0);
    wait_eq(16'h0384, 1'h1, 300, n);
    wait_eq(16'h0384, 1'h0, 300, r);
    chk("rise cycles", TK, r);
    chk("upper clamp", 32'h438, {16'h0, fout});
    wait_eq(16'h0384, 1'h1, 70000, n);
    chk("fall cycles", 32'h3E7 * TK, n);
    chk("period cycles", 32'h3E8 * TK, r + n);
    $display("test period done");
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst_n = 1'h0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_stb = 1'h0;
    rd_stb = 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_defaults();
    t_center_max();
    t_period();
    stop_test();
  end
  initial begin
    repeat (80000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
